// file: logic_rotate_defines.svh
`ifndef LOGIC_ROTATE_DEFINES_SVH
`define LOGIC_ROTATE_DEFINES_SVH

// Register map, byte offsets on the Wishbone port
`define OFS_SOURCE       8'h00
`define OFS_SECOND       8'h04
`define OFS_DEST         8'h08
`define OFS_CONTROL      8'h0c
`define OFS_CONDITION    8'h10
`define OFS_EXCEPTION    8'h14

// Control register fields
`define CTL_OP_LSB       0
`define CTL_OP_MSB       3
`define CTL_UPDATE_BIT   4
`define CTL_LEFT_BIT     5
`define CTL_N_LSB        8
`define CTL_N_MSB        13
`define CTL_B_LSB        16
`define CTL_B_MSB        20
`define CTL_START_BIT    31

// Condition field zero: lt gt eq so in bits 3..0
`define CF_LT_BIT        3
`define CF_GT_BIT        2
`define CF_EQ_BIT        1
`define CF_SO_BIT        0

// Fixed point exception register flag positions
`define XR_SO_BIT        2
`define XR_OV_BIT        1
`define XR_CA_BIT        0

`define RST_WORD         32'h0000_0000
`define RST_CONTROL      32'h0000_0000
`define RST_FLAGS        4'h0
`define RST_EXC          3'h0

`endif

// file: logic_rotate_pkg.sv
package logic_rotate_pkg;

  typedef enum logic [3:0] {
    OP_EQV     = 4'h0,
    OP_ANDC    = 4'h1,
    OP_ORC     = 4'h2,
    OP_EXTSB   = 4'h3,
    OP_EXTSH   = 4'h4,
    OP_CLZ     = 4'h5,
    OP_EXTRACT = 4'h6,
    OP_INSERT  = 4'h7,
    OP_ROTATE  = 4'h8,
    OP_SHIFT   = 4'h9,
    OP_CLEAR   = 4'ha,
    OP_CLRSHL  = 4'hb
  } op_t;

  typedef struct packed {
    logic       start;
    logic [4:0] pos_b;
    logic [5:0] cnt_n;
    logic       left;
    logic       update;
    op_t        op;
  } ctl_t;

  typedef struct packed {
    logic lt;
    logic gt;
    logic eq;
    logic so;
  } cond_t;

endpackage

// file: leading_zero_counter.sv
`timescale 1ns/10ps
`default_nettype none

// Leading zeros counted from the most significant end
module leading_zero_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0]         value_i,
  output logic      [$clog2(WIDTH):0]   count_o
);

  always_comb begin
    logic found;
    found   = 1'b0;
    count_o = ($clog2(WIDTH)+1)'(WIDTH);
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (!found && value_i[i]) begin
        found   = 1'b1;
        count_o = ($clog2(WIDTH)+1)'(WIDTH - 1 - i);
      end
    end
  end

endmodule

`default_nettype wire

// file: integer_logic_rotate_unit.sv
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

`include "logic_rotate_defines.svh"

// How it works
// - Equivalence writes complement of source xor second
// - And-complement writes source and inverted second
// - Or-complement writes source or inverted second
// - Byte extend copies low byte, replicates sign
// - Half extend copies low half, replicates sign
// - Leading-zero count from top, zero to 32
// - Leading-zero count with update clears less-than
// - Only update form modifies condition field zero
// - Extract justifies n-bit field, zeros the rest
// - Insert places n-bit field at b, keeps rest
// - Rotate whole register by n, no mask
// - Logical shift by n, vacated bits zero
// - Clear n leftmost or rightmost bits
// - Clear leftmost b bits then shift left n
// - Condition field zero compares result with zero signed
// - Exception register flags never changed by execution
// - Rotation on 32 bits, bit 0 wraps to 31
module integer_logic_rotate_unit
  import logic_rotate_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   err_o,
  output logic                   busy_o
);

  localparam int SW = $clog2(WIDTH);

  logic [31:0] source_reg_q;
  logic [31:0] second_operand_reg_q;
  logic [31:0] dest_reg_q;
  ctl_t        ctl_q;
  cond_t       condition_field_zero_q;
  logic [2:0]  fixed_point_exception_reg_q;
  logic        busy_q;
  logic [31:0] dat_q;
  logic        ack_q;
  logic        err_q;

  logic        req;
  logic        wr;
  logic        mapped;
  logic [31:0] wmask;
  logic        wr_source;
  logic        wr_second;
  logic        wr_dest;
  logic        wr_ctl;
  logic        wr_cond;
  logic        wr_exc;
  logic        start_hit;
  logic [31:0] ctl_word;
  logic [31:0] ctl_wr;
  logic [31:0] rd_word;

  localparam logic [31:0] CTL_RST = `RST_CONTROL;

  // A pending answer blocks a second take of the same request
  assign req  = cyc_i && stb_i && !ack_q && !err_q;
  assign wr   = req && we_i;

  assign wr_source = wr && (adr_i == `OFS_SOURCE);
  assign wr_second = wr && (adr_i == `OFS_SECOND);
  assign wr_dest   = wr && (adr_i == `OFS_DEST);
  assign wr_ctl    = wr && (adr_i == `OFS_CONTROL);
  assign wr_cond   = wr && (adr_i == `OFS_CONDITION);
  assign wr_exc    = wr && (adr_i == `OFS_EXCEPTION);

  // Start only counts when its byte lane is enabled
  assign start_hit = wr_ctl && sel_i[3] && dat_i[`CTL_START_BIT];
  always_comb begin
    unique case (adr_i)
      `OFS_SOURCE, `OFS_SECOND, `OFS_DEST,
      `OFS_CONTROL, `OFS_CONDITION, `OFS_EXCEPTION: mapped = 1'b1;
      default:                                       mapped = 1'b0;
    endcase
  end

  // Byte lanes expanded to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g +: 8] = {8{sel_i[g]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Datapath. Vector bit i here holds documented bit 31-i, so bit 0 is the MSB.
  logic [WIDTH-1:0]  rs;
  logic [WIDTH-1:0]  rb;
  logic [WIDTH-1:0]  ra_old;
  logic [SW-1:0]     n_amt;
  logic [SW-1:0]     b_pos;
  logic [SW:0]       lz_count;
  logic [WIDTH-1:0]  rot_l;
  logic [WIDTH-1:0]  rot_r;
  logic [WIDTH-1:0]  field_mask;
  logic [WIDTH-1:0]  result;
  logic [2*WIDTH-1:0] dbl;

  assign rs     = source_reg_q[WIDTH-1:0];
  assign rb     = second_operand_reg_q[WIDTH-1:0];
  assign ra_old = dest_reg_q[WIDTH-1:0];
  assign n_amt  = ctl_q.cnt_n[SW-1:0];
  assign b_pos  = ctl_q.pos_b[SW-1:0];
  assign dbl    = {rs, rs};

  // Left rotate moves documented bit 0 around to bit 31
  assign rot_l = dbl[2*WIDTH-1-n_amt -: WIDTH];
  assign rot_r = dbl[n_amt +: WIDTH];

  // Ones in the low n positions, n of 0..32
  assign field_mask = (ctl_q.cnt_n >= 6'(WIDTH)) ? {WIDTH{1'b1}}
                    : ((WIDTH)'(1) << ctl_q.cnt_n) - (WIDTH)'(1);

  leading_zero_counter #(
    .WIDTH (WIDTH)
  ) u_lzc (
    .value_i (rs),
    .count_o (lz_count)
  );

  always_comb begin
    logic [WIDTH-1:0] fld;
    logic [WIDTH-1:0] pos_mask;
    logic [SW:0]      lsb_at;
    fld      = '0;
    pos_mask = '0;
    lsb_at   = '0;
    result   = '0;
    unique case (ctl_q.op)
      OP_EQV:   result = ~(rs ^ rb);
      OP_ANDC:  result = rs & ~rb;
      OP_ORC:   result = rs | ~rb;
      OP_EXTSB: result = {{(WIDTH-8){rs[7]}}, rs[7:0]};
      OP_EXTSH: result = {{(WIDTH-16){rs[15]}}, rs[15:0]};
      OP_CLZ:   result = (WIDTH)'(lz_count);
      OP_EXTRACT: begin
        // Field of n bits from documented bit b; its lsb sits at 32-b-n
        lsb_at = (SW+1)'(WIDTH) - (SW+1)'(b_pos) - (SW+1)'(ctl_q.cnt_n);
        fld    = (rs >> lsb_at) & field_mask;
        if (ctl_q.left) begin
          result = fld << ((SW+1)'(WIDTH) - (SW+1)'(ctl_q.cnt_n));
        end else begin
          result = fld;
        end
      end
      OP_INSERT: begin
        // Low n source bits land at documented bits b..b+n-1
        lsb_at   = (SW+1)'(WIDTH) - (SW+1)'(b_pos) - (SW+1)'(ctl_q.cnt_n);
        pos_mask = field_mask << lsb_at;
        result   = (ra_old & ~pos_mask) | ((rs << lsb_at) & pos_mask);
      end
      OP_ROTATE: result = ctl_q.left ? rot_l : rot_r;
      OP_SHIFT: begin
        if (ctl_q.cnt_n >= 6'(WIDTH)) begin
          result = '0;
        end else if (ctl_q.left) begin
          result = rs << ctl_q.cnt_n;
        end else begin
          result = rs >> ctl_q.cnt_n;
        end
      end
      OP_CLEAR: begin
        if (ctl_q.left) begin
          result = rs & ~(field_mask << ((SW+1)'(WIDTH) - (SW+1)'(ctl_q.cnt_n)));
        end else begin
          result = rs & ~field_mask;
        end
      end
      OP_CLRSHL: begin
        fld    = (b_pos == '0) ? rs : (rs & ({WIDTH{1'b1}} >> b_pos));
        result = (ctl_q.cnt_n >= 6'(WIDTH)) ? '0 : (fld << ctl_q.cnt_n);
      end
      default:  result = ra_old;
    endcase
  end

  // Condition outcome of a signed compare against zero
  cond_t cond_d;
  always_comb begin
    cond_d.lt = result[WIDTH-1];
    cond_d.gt = !result[WIDTH-1] && (result != '0);
    cond_d.eq = (result == '0);
    cond_d.so = fixed_point_exception_reg_q[`XR_SO_BIT];
    if (ctl_q.op == OP_CLZ) begin
      cond_d.lt = 1'b0;
    end
  end

  // One operation executes per start; busy covers that single cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= start_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      source_reg_q         <= `RST_WORD;
      second_operand_reg_q <= `RST_WORD;
    end else begin
      if (wr_source) begin
        source_reg_q <= merge(source_reg_q, dat_i, wmask);
      end
      if (wr_second) begin
        second_operand_reg_q <= merge(second_operand_reg_q, dat_i, wmask);
      end
    end
  end

  // Execution wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_reg_q <= `RST_WORD;
    end else if (busy_q) begin
      dest_reg_q <= 32'(result);
    end else if (wr_dest) begin
      dest_reg_q <= merge(dest_reg_q, dat_i, wmask);
    end
  end

  // Control as software sees it; the stored struct is packed differently
  assign ctl_word = {1'b0, 10'h000, ctl_q.pos_b, 2'h0, ctl_q.cnt_n, 2'h0,
                     ctl_q.left, ctl_q.update, ctl_q.op};
  assign ctl_wr   = merge(ctl_word, dat_i, wmask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q.start  <= 1'b0;
      ctl_q.pos_b  <= CTL_RST[`CTL_B_MSB:`CTL_B_LSB];
      ctl_q.cnt_n  <= CTL_RST[`CTL_N_MSB:`CTL_N_LSB];
      ctl_q.left   <= CTL_RST[`CTL_LEFT_BIT];
      ctl_q.update <= CTL_RST[`CTL_UPDATE_BIT];
      ctl_q.op     <= op_t'(CTL_RST[`CTL_OP_MSB:`CTL_OP_LSB]);
    end else if (wr_ctl) begin
      // Start is a strobe, never stored
      ctl_q.start  <= 1'b0;
      ctl_q.pos_b  <= ctl_wr[`CTL_B_MSB:`CTL_B_LSB];
      ctl_q.cnt_n  <= ctl_wr[`CTL_N_MSB:`CTL_N_LSB];
      ctl_q.left   <= ctl_wr[`CTL_LEFT_BIT];
      ctl_q.update <= ctl_wr[`CTL_UPDATE_BIT];
      ctl_q.op     <= op_t'(ctl_wr[`CTL_OP_MSB:`CTL_OP_LSB]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      condition_field_zero_q <= cond_t'(`RST_FLAGS);
    end else if (busy_q && ctl_q.update) begin
      condition_field_zero_q <= cond_d;
    end else if (wr_cond && sel_i[0]) begin
      condition_field_zero_q <= cond_t'(dat_i[3:0]);
    end
  end

  // Written only by software; execution never changes these flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fixed_point_exception_reg_q <= `RST_EXC;
    end else if (wr_exc && sel_i[0]) begin
      fixed_point_exception_reg_q <= dat_i[2:0];
    end
  end

  // Read word; unmapped offsets read as zero
  always_comb begin
    unique case (adr_i)
      `OFS_SOURCE:    rd_word = source_reg_q;
      `OFS_SECOND:    rd_word = second_operand_reg_q;
      `OFS_DEST:      rd_word = dest_reg_q;
      `OFS_CONTROL:   rd_word = {busy_q, ctl_word[30:0]};
      `OFS_CONDITION: rd_word = {28'h0000000, condition_field_zero_q};
      `OFS_EXCEPTION: rd_word = {29'h00000000, fixed_point_exception_reg_q};
      default:        rd_word = `RST_WORD;
    endcase
  end

  // Data stands only with its answer, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= `RST_WORD;
    end else begin
      ack_q <= req && mapped;
      err_q <= req && !mapped;
      dat_q <= `RST_WORD;
      if (req && !we_i) begin
        dat_q <= rd_word;
      end
    end
  end

  assign dat_o  = dat_q;
  assign ack_o  = ack_q;
  assign err_o  = err_q;
  assign busy_o = busy_q;

endmodule

`default_nettype wire

// file: gpr_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module gpr_bus_master (
  input  wire logic        clk_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end
  // Request held until the edge that sees the answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (!(ack_i || err_i));
    q = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Stale data inverted so nothing leans on it
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// file: integer_logic_rotate_unit_sva.sv
`timescale 1ns/10ps
`default_nettype none
module integer_logic_rotate_unit_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic hit;
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  assign hit  = adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  ack_mapped_a: assert property (take && hit |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");
  err_unmapped_a: assert property (take && !hit |=> err_o && !ack_o && dat_o == 32'h0)
    else $error("unmapped access not refused");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  err_single_a: assert property (err_o |=> !err_o)
    else $error("err longer than one cycle");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  busy_start_a: assert property (take && we_i && adr_i == 8'h0c && sel_i[3] && dat_i[31]
    |=> busy_o ##1 !busy_o) else $error("start not followed by one busy cycle");
  busy_cause_a: assert property (busy_o |-> $past(take && we_i && adr_i == 8'h0c))
    else $error("busy without start write");
  cond_width_a: assert property (take && !we_i && adr_i == 8'h10 |=> dat_o[31:4] == 28'h0)
    else $error("condition read upper bits set");
  exc_width_a: assert property (take && !we_i && adr_i == 8'h14 |=> dat_o[31:3] == 29'h0)
    else $error("exception read upper bits set");
  cover property (busy_o);
  cover property (err_o);
  cover property (take && !we_i && adr_i == 8'h10);
endmodule
`default_nettype wire

// file: tb_integer_logic_rotate_unit.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb_integer_logic_rotate_unit;
  import logic_rotate_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, err, busy;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        e;
  int          fails = 0;
  int          samples_checked = 0;
  always #25 clk_i = ~clk_i;
  integer_logic_rotate_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err), .busy_o(busy));
  gpr_bus_master bus_u (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .err_i(err), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_u.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus_u.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask
  task automatic run(input op_t o, input logic [5:0] n, input logic [4:0] b,
                     input logic l, input logic u);
    wr(8'h0c, {1'b1, 10'h0, b, 2'h0, n, 2'h0, l, u, o});
  endtask
  task automatic t_logic();
    logic [31:0] s, t;
    s = 32'hf0f0_1234;
    t = 32'h0ff0_00ff;
    wr(8'h00, s);
    wr(8'h04, t);
    run(OP_EQV, 0, 0, 0, 0);
    rd(8'h08, ~(s ^ t));
    run(OP_ANDC, 0, 0, 0, 0);
    rd(8'h08, s & ~t);
    run(OP_ORC, 0, 0, 0, 0);
    rd(8'h08, s | ~t);
  endtask
  task automatic t_ext();
    wr(8'h00, 32'h1234_8001);
    run(OP_EXTSH, 0, 0, 0, 0);
    rd(8'h08, 32'hffff_8001);
    run(OP_EXTSB, 0, 0, 0, 0);
    rd(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0080);
    run(OP_EXTSB, 0, 0, 0, 0);
    rd(8'h08, 32'hffff_ff80);
  endtask
  task automatic t_clz();
    wr(8'h00, 32'h0);
    run(OP_CLZ, 0, 0, 0, 1);
    rd(8'h08, 32'h20);
    rd(8'h10, 32'h4);
    wr(8'h00, 32'h0000_1000);
    run(OP_CLZ, 0, 0, 0, 0);
    rd(8'h08, 32'd19);
    wr(8'h00, 32'h8000_0000);
    run(OP_CLZ, 0, 0, 0, 1);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h2);
  endtask
  task automatic t_upd();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    run(OP_EQV, 0, 0, 0, 0);
    rd(8'h10, 32'h2);
    run(OP_EQV, 0, 0, 0, 1);
    rd(8'h10, 32'h8);
  endtask
  task automatic t_rot();
    wr(8'h00, 32'h1234_5678);
    run(OP_ROTATE, 4, 0, 1, 0);
    rd(8'h08, 32'h2345_6781);
    run(OP_ROTATE, 4, 0, 0, 0);
    rd(8'h08, 32'h8123_4567);
    run(OP_ROTATE, 32, 0, 1, 0);
    rd(8'h08, 32'h1234_5678);
    run(OP_SHIFT, 8, 0, 1, 0);
    rd(8'h08, 32'h3456_7800);
    run(OP_SHIFT, 4, 0, 0, 0);
    rd(8'h08, 32'h0123_4567);
    run(OP_SHIFT, 32, 0, 0, 0);
    rd(8'h08, 32'h0);
  endtask
  task automatic t_clear();
    wr(8'h00, 32'hf234_5678);
    run(OP_CLEAR, 4, 0, 1, 0);
    rd(8'h08, 32'h0234_5678);
    run(OP_CLEAR, 8, 0, 0, 0);
    rd(8'h08, 32'hf234_5600);
    run(OP_CLRSHL, 4, 8, 0, 0);
    rd(8'h08, 32'h0345_6780);
  endtask
  task automatic t_field();
    wr(8'h00, 32'h1234_5678);
    run(OP_EXTRACT, 8, 8, 0, 0);
    rd(8'h08, 32'h0000_0034);
    run(OP_EXTRACT, 8, 8, 1, 0);
    rd(8'h08, 32'h3400_0000);
    wr(8'h00, 32'h0000_0012);
    run(OP_INSERT, 8, 8, 0, 0);
    rd(8'h08, 32'h3412_0000);
  endtask
  task automatic t_bus();
    rd(8'h14, 32'h0);
    wr(8'h14, 32'h7);
    run(OP_EQV, 0, 0, 0, 1);
    rd(8'h14, 32'h7);
    rd(8'h10, 32'h9);
    rd(8'h20, 32'h0);
    `CHK(e, 1'b1)
  endtask
  task automatic end_sim();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_logic();
    t_ext();
    t_clz();
    t_upd();
    t_rot();
    t_clear();
    t_field();
    t_bus();
    end_sim();
  end
endmodule
bind integer_logic_rotate_unit integer_logic_rotate_unit_chk chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .busy_o(busy_o));
`default_nettype wire
